// [verilog/fnd_params.svh]
// constants for the fractional-n divider control block
// assumes a 32-bit apb slave and a 100 MHz pclk standing for the vco edge
`ifndef FND_PARAMS_SVH
`define FND_PARAMS_SVH

// register byte addresses
`define FND_ADDR_CTRL 12'h000
`define FND_ADDR_WORD 12'h004
`define FND_ADDR_STATUS 12'h008
`define FND_ADDR_WORKING 12'h00c

// ctrl fields
`define FND_CTRL_EN_BIT 0

// divider word fields
`define FND_A_LSB 0
`define FND_A_MSB 4
`define FND_B_LSB 5
`define FND_B_MSB 17
`define FND_INCR_LSB 18
`define FND_INCR_MSB 21
`define FND_MOD_LSB 22
`define FND_MOD_MSB 26
`define FND_WORD_MSB 26

// status fields
`define FND_ST_ACC_LSB 0
`define FND_ST_ACC_MSB 3
`define FND_ST_PEND_BIT 4
`define FND_ST_EN_BIT 5
`define FND_ST_PLUS_BIT 6

// reset values: a=0, b=31, increment 0, modulus 1
`define FND_CTRL_RST 1'h0
`define FND_WORD_RST 27'h04003e0

// prescaler count (cycles minus one) and largest modulus
`define FND_PRE_LOW 6'h1f
`define FND_MOD_MAX 5'h10

`endif

// [verilog/fnd_pkg.sv]
// types shared by the fractional-n divider control files
// assumes fnd_params.svh supplies the numeric constants
package fnd_pkg;

  // divider word as held pending and working
  typedef struct packed {
    logic [4:0] fraction_modulus;
    logic [3:0] fractional_increment;
    logic [12:0] b_count;
    logic [4:0] a_count;
  } fnd_word_t;

  // strobes and levels toward prescaler and phase detector
  typedef struct packed {
    logic input_stage_en;
    logic modulus_33;
    logic sync;
    logic pd_pulse;
  } fnd_div_out_t;

endpackage : fnd_pkg

// [verilog/fnd_accum.sv]
// modulo fractional accumulator stepped once per divider cycle
// assumes increment below modulus and modulus 1..16, checked by the caller
`timescale 1ns/10ps
module fnd_accum #(
  parameter int ACC_W = 4,
  parameter int MOD_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic clr,
  input wire logic [ACC_W-1:0] incr,
  input wire logic [MOD_W-1:0] modulus,
  output logic [ACC_W-1:0] acc_q,
  output logic carry_q
);
  import fnd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [MOD_W-1:0] sum_w;
  logic ovf_w;
  logic [MOD_W-1:0] wrap_w;
  logic [ACC_W-1:0] acc_d;
  logic carry_d;

  assign sum_w = MOD_W'(acc_q) + MOD_W'(incr); // [RULE5] [RULE7]
  assign ovf_w = (sum_w >= modulus); // [RULE6]
  assign wrap_w = ovf_w ? (sum_w - modulus) : sum_w; // [RULE5]
  // clear wins over the step so a fresh word always restarts at zero
  assign acc_d = clr ? '0 : (step ? ACC_W'(wrap_w) : acc_q); // [RULE14]
  assign carry_d = clr ? 1'b0 : (step ? ovf_w : carry_q); // [RULE6]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      carry_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_acc_below_mod;
    @(posedge pclk) disable iff (!presetn)
    MOD_W'(acc_q) < modulus || modulus == '0;
  endproperty
  a_acc_below_mod: assert property (p_acc_below_mod) // [RULE4]
    else $error("accumulator not below modulus");

  property p_step_wraps;
    @(posedge pclk) disable iff (!presetn)
    (step && !clr) |=> MOD_W'(acc_q) ==
      (($past(sum_w) >= $past(modulus)) ? $past(sum_w) - $past(modulus)
                                        : $past(sum_w));
  endproperty
  a_step_wraps: assert property (p_step_wraps) // [RULE5]
    else $error("accumulator step not modulo");

  property p_carry_on_ovf;
    @(posedge pclk) disable iff (!presetn)
    (step && !clr) |=> carry_q == ($past(sum_w) >= $past(modulus));
  endproperty
  a_carry_on_ovf: assert property (p_carry_on_ovf) // [RULE6]
    else $error("carry does not match overflow");

  property p_zero_incr_holds;
    @(posedge pclk) disable iff (!presetn)
    (incr == '0 && acc_q == '0 && !carry_q) |=> (acc_q == '0 && !carry_q);
  endproperty
  a_zero_incr_holds: assert property (p_zero_incr_holds) // [RULE8]
    else $error("integer channel left zero");

  property p_clr_zero;
    @(posedge pclk) disable iff (!presetn)
    clr |=> (acc_q == '0 && !carry_q);
  endproperty
  a_clr_zero: assert property (p_clr_zero) // [RULE14]
    else $error("accumulator not cleared on load");

endmodule : fnd_accum

// [verilog/fnd_top.sv]
// fractional-n main divider control with apb register access
// assumes pclk stands in for the vco edge; latch strobe is an async pin
//
// Overview of operation
// [RULE1] a pending word moves to the working registers only at sync.
// [RULE2] terminal count raises sync and one phase detector pulse together.
// [RULE3] the word loads only if the latch strobe is high at sync.
// [RULE4] increment must be below modulus and modulus within 1 to 16.
// [RULE5] each divider cycle end adds the increment modulo the modulus.
// [RULE6] an overflow makes the next cycle divide by n+1, else by n.
// [RULE7] increment 3 modulus 8 steps 3,6,1,4,7,2,5,0 with carries on 1,2,0.
// [RULE8] a zero increment keeps the accumulator at zero, dividing by n.
// [RULE9] accumulator contents feed the compensation output each cycle.
// [RULE10] prescaler runs 33 while a counts, then 32 until b ends.
// [RULE11] software keeps a no larger than b; total is 32(b-a)+33a.
// [RULE12] the input stage runs only while the enable bit is one.
// [RULE13] increment is a 4-bit field and modulus a 5-bit field.
// [RULE14] the accumulator clears on reset and on each word load.
`timescale 1ns/10ps
`include "fnd_params.svh"
module fnd_top #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic latch_strobe,
  output fnd_pkg::fnd_div_out_t div_out,
  output logic [3:0] proportional_pump_output
);
  import fnd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state; a write lands at the last edge, read data is registered one edge earlier with pready
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic main_divider_enable_q;
  fnd_word_t pend_q;
  fnd_word_t work_q;
  logic pend_valid_q;
  logic [3:0] acc_w;
  logic plus_one_w;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic acc_done;
  logic wr_done;

  assign acc_done = psel && penable && pready_q;
  assign wr_done = acc_done && pwrite && !pslverr_q;
  assign addr_ok = (paddr == `FND_ADDR_CTRL) || (paddr == `FND_ADDR_WORD) ||
                   (paddr == `FND_ADDR_STATUS) ||
                   (paddr == `FND_ADDR_WORKING);

  assign rd_mux =
    (paddr == `FND_ADDR_CTRL) ? {31'h0, main_divider_enable_q} :
    (paddr == `FND_ADDR_WORD) ? {5'h0, pend_q} :
    (paddr == `FND_ADDR_STATUS) ?
      {25'h0, plus_one_w, main_divider_enable_q, pend_valid_q, acc_w} :
    (paddr == `FND_ADDR_WORKING) ? {5'h0, work_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      prdata_q <= (psel && !pwrite) ? rd_mux : 32'h0;
      pslverr_q <= psel && penable && !pready_q && !addr_ok;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // latch strobe: three stages, level moves once stages two and three agree
  logic [2:0] stb_sync_q;
  logic strobe_level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_sync_q <= 3'h0;
      strobe_level_q <= 1'b0;
    end else begin
      stb_sync_q <= {stb_sync_q[1:0], latch_strobe};
      if (stb_sync_q[1] == stb_sync_q[2]) begin
        strobe_level_q <= stb_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divider counters
  logic [5:0] pre_cnt_q;
  logic [12:0] b_cnt_q;
  logic in_a_w;
  logic b_last_w;
  logic [5:0] pre_top_w;
  logic pre_last_w;
  logic term_w;
  logic load_w;

  assign in_a_w = ({8'h0, work_q.a_count} > b_cnt_q); // [RULE10] [RULE11]
  // b of zero is out of range; it is then treated as one prescaler cycle
  assign b_last_w = (14'(b_cnt_q) + 14'h1 >= 14'(work_q.b_count)); // [RULE10]
  // the extra vco cycle of an n+1 division is swallowed in the last cycle
  assign pre_top_w = `FND_PRE_LOW + 6'(in_a_w) +
                     6'(plus_one_w && b_last_w); // [RULE6] [RULE10]
  assign pre_last_w = (pre_cnt_q >= pre_top_w);
  assign term_w = main_divider_enable_q && pre_last_w && b_last_w; // [RULE2]
  assign load_w = term_w && strobe_level_q && pend_valid_q; // [RULE1] [RULE3]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 6'h0;
      b_cnt_q <= 13'h0;
    end else if (!main_divider_enable_q) begin
      pre_cnt_q <= 6'h0; // [RULE12]
      b_cnt_q <= 13'h0;
    end else if (pre_last_w) begin
      pre_cnt_q <= 6'h0;
      b_cnt_q <= b_last_w ? 13'h0 : b_cnt_q + 13'h1; // [RULE10]
    end else begin
      pre_cnt_q <= pre_cnt_q + 6'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers: pending word, its flag, and working copy
  fnd_word_t wdata_w;

  assign wdata_w = fnd_word_t'(pwdata[`FND_WORD_MSB:0]); // [RULE13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_divider_enable_q <= `FND_CTRL_RST;
      pend_q <= fnd_word_t'(`FND_WORD_RST);
      work_q <= fnd_word_t'(`FND_WORD_RST);
      pend_valid_q <= 1'b0;
    end else begin
      if (wr_done && paddr == `FND_ADDR_CTRL) begin
        main_divider_enable_q <= pwdata[`FND_CTRL_EN_BIT]; // [RULE12]
      end
      if (wr_done && paddr == `FND_ADDR_WORD) begin
        pend_q <= wdata_w;
      end
      // a write in the load cycle keeps the flag set for the new word
      if (wr_done && paddr == `FND_ADDR_WORD) begin
        pend_valid_q <= 1'b1;
      end else if (load_w) begin
        pend_valid_q <= 1'b0;
      end
      if (load_w) begin
        work_q <= pend_q; // [RULE1] [RULE3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fractional accumulator; an illegal pair falls back to an integer channel
  logic frac_ok_w;
  logic [3:0] incr_eff_w;
  logic [4:0] mod_eff_w;

  assign frac_ok_w = (work_q.fraction_modulus != 5'h0) &&
                     (work_q.fraction_modulus <= `FND_MOD_MAX) &&
                     ({1'b0, work_q.fractional_increment} <
                      work_q.fraction_modulus); // [RULE4]
  assign incr_eff_w = frac_ok_w ? work_q.fractional_increment : 4'h0;
  assign mod_eff_w = frac_ok_w ? work_q.fraction_modulus : 5'h1; // [RULE8]

  fnd_accum #(
    .ACC_W(4),
    .MOD_W(5)
  ) u_accum (
    .pclk(pclk),
    .presetn(presetn),
    .step(term_w), // [RULE5]
    .clr(load_w), // [RULE14]
    .incr(incr_eff_w),
    .modulus(mod_eff_w),
    .acc_q(acc_w),
    .carry_q(plus_one_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  fnd_div_out_t div_out_q;
  logic [3:0] comp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_out_q <= '0;
      comp_q <= 4'h0;
    end else begin
      div_out_q.input_stage_en <= main_divider_enable_q; // [RULE12]
      div_out_q.modulus_33 <= main_divider_enable_q && in_a_w; // [RULE10]
      div_out_q.sync <= term_w; // [RULE2]
      div_out_q.pd_pulse <= term_w; // [RULE2]
      comp_q <= acc_w; // [RULE9]
    end
  end

  assign div_out = div_out_q;
  assign proportional_pump_output = comp_q;

  ////////////////////////////////////////////////////////////////////////
  property p_load_at_sync;
    @(posedge pclk) disable iff (!presetn)
    (work_q != $past(work_q)) |-> $past(term_w);
  endproperty
  a_load_at_sync: assert property (p_load_at_sync) // [RULE1]
    else $error("working word changed away from terminal count");

  property p_sync_with_pulse;
    @(posedge pclk) disable iff (!presetn)
    term_w |=> (div_out_q.sync && div_out_q.pd_pulse);
  endproperty
  a_sync_with_pulse: assert property (p_sync_with_pulse) // [RULE2]
    else $error("sync and phase detector pulse not together");

  property p_load_needs_strobe;
    @(posedge pclk) disable iff (!presetn)
    (work_q != $past(work_q)) |-> $past(strobe_level_q);
  endproperty
  a_load_needs_strobe: assert property (p_load_needs_strobe) // [RULE3]
    else $error("word loaded without latch strobe");

  property p_comp_tracks;
    @(posedge pclk) disable iff (!presetn)
    term_w |-> ##2 (comp_q == $past(acc_w, 1));
  endproperty
  a_comp_tracks: assert property (p_comp_tracks) // [RULE9]
    else $error("compensation does not follow accumulator");

  property p_a_phase_33;
    @(posedge pclk) disable iff (!presetn)
    (main_divider_enable_q && b_cnt_q == 13'h0 && work_q.a_count != 5'h0)
      |=> div_out_q.modulus_33;
  endproperty
  a_a_phase_33: assert property (p_a_phase_33) // [RULE10]
    else $error("prescaler not at 33 during a phase");

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
    !main_divider_enable_q [*2] |=> (!div_out_q.input_stage_en &&
                                     !div_out_q.sync);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // [RULE12]
    else $error("input stage active while disabled");

endmodule : fnd_top

// [bench/fnd_partner.sv]
// partner: latch strobe of the programming side, phase detector gap meter
// assumes pd_pulse is a one-cycle pulse on pclk
`timescale 1ns/10ps
module fnd_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strobe_req,
  input wire logic pd_pulse,
  input wire logic modulus_33,
  output logic latch_strobe,
  output logic [15:0] gap_q,
  output logic [15:0] a_gap_q
);
  logic [15:0] cnt_q;
  logic [15:0] a_cnt_q;
  ////////////////////////////////////////////////////////////////////////
  // strobe stays up until the bench sees the load, so it spans sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_strobe <= 1'b0;
    end else begin
      latch_strobe <= strobe_req;
    end
  end
  // pclk count from one phase detector pulse to the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0;
      gap_q <= 16'h0;
    end else if (pd_pulse) begin
      gap_q <= cnt_q;
      cnt_q <= 16'h1;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
  // cycles spent dividing by 33 within each division
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_cnt_q <= 16'h0;
      a_gap_q <= 16'h0;
    end else if (pd_pulse) begin
      a_gap_q <= a_cnt_q + 16'(modulus_33);
      a_cnt_q <= 16'h0;
    end else begin
      a_cnt_q <= a_cnt_q + 16'(modulus_33);
    end
  end
endmodule : fnd_partner

// [bench/fnd_top_test.sv]
// self-checking bench for the fractional-n divider control
// assumes fnd_partner drives the latch strobe and measures sync gaps
`timescale 1ns/10ps
`include "fnd_params.svh"
module fnd_top_test;
  import fnd_pkg::*;
  typedef struct {int a; int b; int incr; int md; int nd;} fnd_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic strobe_req = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, latch_strobe;
  fnd_div_out_t div_out;
  logic [3:0] prop;
  logic [15:0] gap, a_gap;
  fnd_word_t w, old_w;
  int bad_count = 0;
  int compares = 0;
  int acc, cy, n;
  // a never above b incr below modulus, modulus 1..16
  // last field: integer division 32b+a expected for the row
  fnd_row_t rows[5] = '{'{1, 2, 3, 8, 65}, '{0, 3, 6, 8, 96},
    '{2, 2, 0, 1, 66}, '{3, 5, 15, 16, 163}, '{0, 2, 5, 16, 64}};

  fnd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .latch_strobe(latch_strobe), .div_out(div_out),
    .proportional_pump_output(prop));
  fnd_partner part_u (.pclk(pclk), .presetn(presetn),
    .strobe_req(strobe_req), .pd_pulse(div_out.pd_pulse),
    .modulus_33(div_out.modulus_33), .latch_strobe(latch_strobe),
    .gap_q(gap), .a_gap_q(a_gap));

  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // waits one idle edge first so back-to-back calls never redrive psel
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; it has no cycle limit, so only the watchdog stops it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_sync;
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (div_out.sync !== 1'b1 && k < 9000);
    chk("pd_pulse", {31'h0, div_out.pd_pulse}, 32'h1);
  endtask : wait_sync

  task load(input fnd_word_t nw);
    int k;
    k = 0;
    apb(1'b1, `FND_ADDR_WORD, {5'h0, nw});
    strobe_req <= 1'b1;
    do begin
      apb(1'b0, `FND_ADDR_STATUS, 32'h0);
      k++;
    // a load may wait a whole division of the old word
    end while (rd[`FND_ST_PEND_BIT] !== 1'b0 && k < 2000);
    strobe_req <= 1'b0;
    chk("load", {31'h0, rd[`FND_ST_PEND_BIT]}, 32'h0);
  endtask : load

  task tally_and_finish;
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `FND_ADDR_CTRL, 32'h1);
    foreach (rows[i]) begin
      w = '{5'(rows[i].md), 4'(rows[i].incr), 13'(rows[i].b), 5'(rows[i].a)};
      load(w);
      n = rows[i].nd;
      acc = 0;
      cy = 0;
      repeat (8) begin
        wait_sync();
        @(posedge pclk);
        chk("gap", {16'h0, gap}, n + cy);
        chk("a_phase", {16'h0, a_gap}, 33 * rows[i].a);
        acc = acc + rows[i].incr;
        cy = (acc >= rows[i].md);
        if (cy) acc = acc - rows[i].md;
        chk("acc", {28'h0, prop}, acc);
      end
    end
    // word written with strobe low must stay pending across divisions
    old_w = w;
    w = '{5'h2, 4'h1, 13'h1, 5'h0};
    apb(1'b1, `FND_ADDR_WORD, {5'h0, w});
    wait_sync();
    wait_sync();
    apb(1'b0, `FND_ADDR_WORKING, 32'h0);
    chk("held", rd, {5'h0, old_w});
    apb(1'b0, `FND_ADDR_STATUS, 32'h0);
    chk("pend", {31'h0, rd[`FND_ST_PEND_BIT]}, 32'h1);
    load(w);
    apb(1'b0, `FND_ADDR_WORKING, 32'h0);
    chk("work", rd, {5'h0, w});
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    chk("rd0", rd, 32'h0);
    apb(1'b1, `FND_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      n += div_out.sync;
    end
    chk("quiet", n, 0);
    chk("stage", {31'h0, div_out.input_stage_en}, 32'h0);
    apb(1'b1, `FND_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk("stage", {31'h0, div_out.input_stage_en}, 32'h1);
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("rst_out", {24'h0, div_out, prop}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, `FND_ADDR_WORKING, 32'h0);
    chk("rst_work", rd, {5'h0, `FND_WORD_RST});
    apb(1'b0, `FND_ADDR_STATUS, 32'h0);
    chk("rst_stat", rd, 32'h0);
    apb(1'b0, `FND_ADDR_CTRL, 32'h0);
    chk("rst_ctrl", rd, 32'h0);
    tally_and_finish();
  end

  // the run needs some 6k cycles; this limit is far above it
  initial begin
    #800_000;
    bad_count++;
    tally_and_finish();
  end
endmodule : fnd_top_test
